// [include/wa_pkg.sv]
// Shared types and constants of the receive word boundary aligner.
// Assumes one parallel receive clock for the aligner and its registers.
package wa_pkg;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] addr;
    logic [31:0] wdata;
  } reg_req_t;

  typedef enum logic [1:0] {W8, W10, W16, W20} width_sel_t;
  typedef enum logic [1:0] {MODE_SLIP, MODE_MANUAL, MODE_AUTO} mode_t;
  typedef enum logic [2:0] {
    PROTO_BASIC, PROTO_PCIE, PROTO_XAUI, PROTO_GBE, PROTO_SRIO
  } proto_t;

  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_PAT = 4'h1;
  localparam logic [3:0] ADDR_PLEN = 4'h2;
  localparam logic [3:0] ADDR_SYNC = 4'h3;
  localparam logic [3:0] ADDR_STAT = 4'h4;

  localparam int CTRL_W_LSB = 0;
  localparam int CTRL_MODE_LSB = 2;
  localparam int CTRL_PROTO_LSB = 4;
  localparam int SYNC_ACQ_LSB = 0;
  localparam int SYNC_LOSE_LSB = 8;
  localparam int SYNC_DEC_LSB = 16;

  localparam logic [6:0] CTRL_RST = 7'h00;
  localparam logic [31:0] PAT_RST = 32'h0000_0f1e;
  localparam logic [5:0] PLEN_RST = 6'h10;
  localparam logic [23:0] SYNC_RST = 24'h03_03_03;

  localparam logic [4:0] WBITS_8 = 5'h08;
  localparam logic [4:0] WBITS_10 = 5'h0a;
  localparam logic [4:0] WBITS_16 = 5'h10;
  localparam logic [4:0] WBITS_20 = 5'h14;

  localparam logic [31:0] PROTO_PAT = 32'h0000_007c;
  localparam logic [5:0] PROTO_PLEN = 6'h07;

  localparam logic [8:0] PCIE_ACQ = 9'h004;
  localparam logic [6:0] PCIE_LOSE = 7'h11;
  localparam logic [8:0] PCIE_DEC = 9'h010;
  localparam logic [8:0] XAUI_ACQ = 9'h004;
  localparam logic [6:0] XAUI_LOSE = 7'h04;
  localparam logic [8:0] XAUI_DEC = 9'h004;
  localparam logic [8:0] GBE_ACQ = 9'h003;
  localparam logic [6:0] GBE_LOSE = 7'h04;
  localparam logic [8:0] GBE_DEC = 9'h004;
  localparam logic [8:0] SRIO_ACQ = 9'h07f;
  localparam logic [6:0] SRIO_LOSE = 7'h03;
  localparam logic [8:0] SRIO_DEC = 9'h0ff;

endpackage : wa_pkg

// [logic/wa_window.sv]
// Candidate word boundaries and pattern matches over the raw stream.
// Assumes the three newest raw words, oldest in p2, bit 0 received first.
`timescale 1ns/1ns
module wa_window (
  input wire logic [19:0] cur,
  input wire logic [19:0] p1,
  input wire logic [19:0] p2,
  input wire logic [4:0] wbits,
  input wire logic [4:0] off,
  input wire logic [5:0] plen,
  input wire logic [31:0] pattern,
  output logic [19:0] aligned,
  output logic [19:0] match_vec
);
  logic [39:0] s_now;
  logic [39:0] s_prev;
  logic [39:0] pmask;
  logic [39:0] pat40;
  logic [19:0] wmask;

  assign wmask = 20'((21'h1 << wbits) - 21'h1);
  assign s_now = ({20'h0, cur} << wbits) | {20'h0, p1};
  assign s_prev = ({20'h0, p1} << wbits) | {20'h0, p2};
  assign pmask = (40'h1 << plen) - 40'h1;
  assign pat40 = {8'h00, pattern} & pmask;
  // A slip pulls the next word's first bit into the top position.
  assign aligned = 20'(s_now >> off) & wmask;

  // Short patterns sit in the low bits of one word; long ones span the
  // earlier word as low part and the later word as high part.
  genvar g;
  generate
    for (g = 0; g < 20; g++) begin : g_off
      logic [19:0] now_g;
      logic [19:0] prev_g;
      logic [39:0] pair_g;
      assign now_g = 20'(s_now >> g) & wmask;
      assign prev_g = 20'(s_prev >> g) & wmask;
      assign pair_g = ({20'h0, now_g} << wbits) | {20'h0, prev_g};
      assign match_vec[g] = (5'(g) < wbits) &&
        ((plen <= {1'b0, wbits}) ? (({20'h0, now_g} & pmask) == pat40)
                                 : ((pair_g & pmask) == pat40));
    end
  endgenerate
endmodule : wa_window

// [logic/wa_sync_fsm.sv]
// Synchronisation state machine with acquire and loss hysteresis.
// Assumes one flag per code group for sync groups and for coding errors.
`timescale 1ns/1ns
module wa_sync_fsm (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic enable,
  input wire logic good_grp,
  input wire logic err_grp,
  input wire logic [8:0] acq_n,
  input wire logic [6:0] lose_n,
  input wire logic [8:0] dec_n,
  output logic synced
);
  typedef enum logic {ST_LOSS, ST_SYNC} sync_st_t;
  sync_st_t st_r;
  logic [8:0] acq_cnt_r;
  logic [6:0] err_cnt_r;
  logic [8:0] dec_cnt_r;
  logic acq_hit;
  logic lose_hit;
  logic dec_hit;

  assign acq_hit = good_grp && !err_grp && (9'(acq_cnt_r + 9'h1) == acq_n);
  assign lose_hit = err_grp && (7'(err_cnt_r + 7'h1) == lose_n);
  assign dec_hit = !err_grp && (err_cnt_r != 7'h0) &&
                   (9'(dec_cnt_r + 9'h1) == dec_n);
  assign synced = (st_r == ST_SYNC);

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= ST_LOSS;
    end else if (!enable) begin
      st_r <= ST_LOSS;
    end else begin
      case (st_r)
        ST_LOSS: if (acq_hit) st_r <= ST_SYNC;
        ST_SYNC: if (lose_hit) st_r <= ST_LOSS;
        default: st_r <= ST_LOSS;
      endcase
    end
  end

  // An error clears the acquire count, so only good groups with no error between them acquire.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      acq_cnt_r <= 9'h000;
    end else if (!enable || st_r == ST_SYNC || err_grp || acq_hit) begin
      acq_cnt_r <= 9'h000;
    end else if (good_grp) begin
      acq_cnt_r <= 9'(acq_cnt_r + 9'h1);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      err_cnt_r <= 7'h00;
      dec_cnt_r <= 9'h000;
    end else if (!enable || st_r == ST_LOSS || lose_hit) begin
      err_cnt_r <= 7'h00;
      dec_cnt_r <= 9'h000;
    end else if (err_grp) begin
      err_cnt_r <= 7'(err_cnt_r + 7'h1);
      dec_cnt_r <= 9'h000;
    end else if (dec_hit) begin
      err_cnt_r <= 7'(err_cnt_r - 7'h1);
      dec_cnt_r <= 9'h000;
    end else if (err_cnt_r != 7'h0) begin
      dec_cnt_r <= 9'(dec_cnt_r + 9'h1);
    end
  end

  a_acq_count: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (st_r == ST_LOSS && enable) ##1 (st_r == ST_SYNC) |->
      $past(acq_cnt_r) == 9'(acq_n - 9'h1))
    else $error("sync acquired before the acquire count");

  a_lose_count: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (st_r == ST_SYNC && enable) ##1 (st_r == ST_LOSS) |->
      $past(err_grp) && $past(err_cnt_r) == 7'(lose_n - 7'h1))
    else $error("sync lost before the error count");

  a_hyst_hold: assert property (@(posedge clk_sys) disable iff (!rst_b)
    synced && enable && !err_grp ##1 enable |-> synced)
    else $error("sync dropped without an errored group");
endmodule : wa_sync_fsm

// [logic/rx_word_boundary_aligner.sv]
// Receive word boundary aligner: bit slip and manual alignment over 8, 10, 16
// and 20 bit parallel words, automatic synchronisation over 10 bit words.
// Assumes raw words, slip request, realign permit and code error flags all
// come from logic on the parallel receive clock.
//
// Behaviour
// - Each slip rising edge shifts boundary one bit.
// - Eight bit slip: two words match sixteen bit pattern.
// - Sixteen bit slip behaves as eight bit slip.
// - Twenty bit width allows only manual or slip.
// - Twenty bit manual behaves as sixteen bit manual.
// - Twenty bit slip behaves as eight bit slip.
// - Double width slip shares single width logic.
// - Single width manual lock pulses on new boundary.
// - Pattern hit pulses when pattern in boundary.
// - Eight bit manual reacts to permit rising edges.
// - Double width manual lock stays high once locked.
// - Permit rising edge drops double width lock.
// - Ten bit coded data uses automatic synchronisation.
// - Synchronisation has acquire and loss hysteresis.
// - Protocol modes force automatic synchronisation and comma.
// - Basic ten bit may select automatic synchronisation.
// - Thresholds fixed per protocol, programmable in basic.
// - Basic thresholds span 1-256, 1-64, 1-256.
// - Lock follows acquire count, drops after error count.
// - Eight bit edge hunts; ten bit hunts while permitted.
// - Double width locks first pattern after reset.
`timescale 1ns/1ns
module rx_word_boundary_aligner (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [19:0] rx_data_in,
  input wire logic code_err,
  input wire logic slip_req,
  input wire logic realign_en,
  input wire wa_pkg::reg_req_t reg_req,
  output logic [31:0] reg_rdata,
  output logic [19:0] rx_data_out,
  output logic pattern_hit,
  output logic lock_status
);
  import wa_pkg::*;

  logic [6:0] ctrl_r;
  logic [31:0] pat_r;
  logic [5:0] plen_r;
  logic [23:0] syncc_r;
  logic [31:0] rdata_r;
  logic [19:0] p1_r;
  logic [19:0] p2_r;
  logic [4:0] off_r;
  logic slip_d_r;
  logic realign_d_r;
  logic armed_r;
  logic stat_r;
  logic [19:0] data_out_r;
  logic hit_r;
  logic lock_r;

  width_sel_t wsel;
  mode_t mode;
  proto_t proto;
  logic [4:0] wbits;
  logic double_w;
  logic [31:0] pat_use;
  logic [5:0] plen_use;
  logic [8:0] acq_n;
  logic [6:0] lose_n;
  logic [8:0] dec_n;
  logic [19:0] aligned;
  logic [19:0] match_vec;
  logic [4:0] first_off;
  logic any_match;
  logic hunt_en;
  logic take;
  logic [4:0] new_off;
  logic [4:0] off_use;
  logic slip_rise;
  logic realign_rise;
  logic fsm_synced;
  logic auto_mode;
  logic [39:0] slip_cat;
  logic [39:0] slip_mask;
  logic slip_pair;
  logic hit_src;

  // Protocol modes pin the width to ten bits and force automatic mode;
  // automatic mode on any other width falls back to manual alignment.
  always_comb begin
    proto = proto_t'(ctrl_r[CTRL_PROTO_LSB +: 3]);
    wsel = width_sel_t'(ctrl_r[CTRL_W_LSB +: 2]);
    mode = mode_t'(ctrl_r[CTRL_MODE_LSB +: 2]);
    if (proto != PROTO_BASIC) begin
      wsel = W10;
      mode = MODE_AUTO;
    end
    if (mode == MODE_AUTO && wsel != W10) begin
      mode = MODE_MANUAL;
    end
  end

  always_comb begin
    case (wsel)
      W8: wbits = WBITS_8;
      W10: wbits = WBITS_10;
      W16: wbits = WBITS_16;
      W20: wbits = WBITS_20;
      default: wbits = WBITS_8;
    endcase
  end

  assign double_w = (wsel == W16) || (wsel == W20);
  assign auto_mode = (mode == MODE_AUTO);
  assign pat_use = (proto != PROTO_BASIC) ? PROTO_PAT : pat_r;
  assign plen_use = (proto != PROTO_BASIC) ? PROTO_PLEN : plen_r;

  // Thresholds are stored minus one so every field value is legal.
  always_comb begin
    case (proto)
      PROTO_PCIE: begin
        acq_n = PCIE_ACQ;
        lose_n = PCIE_LOSE;
        dec_n = PCIE_DEC;
      end
      PROTO_XAUI: begin
        acq_n = XAUI_ACQ;
        lose_n = XAUI_LOSE;
        dec_n = XAUI_DEC;
      end
      PROTO_GBE: begin
        acq_n = GBE_ACQ;
        lose_n = GBE_LOSE;
        dec_n = GBE_DEC;
      end
      PROTO_SRIO: begin
        acq_n = SRIO_ACQ;
        lose_n = SRIO_LOSE;
        dec_n = SRIO_DEC;
      end
      default: begin
        acq_n = 9'({1'b0, syncc_r[SYNC_ACQ_LSB +: 8]} + 9'h1);
        lose_n = 7'({1'b0, syncc_r[SYNC_LOSE_LSB +: 6]} + 7'h1);
        dec_n = 9'({1'b0, syncc_r[SYNC_DEC_LSB +: 8]} + 9'h1);
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_r <= CTRL_RST;
      pat_r <= PAT_RST;
      plen_r <= PLEN_RST;
      syncc_r <= SYNC_RST;
    end else if (reg_req.wr) begin
      case (reg_req.addr)
        ADDR_CTRL: ctrl_r <= reg_req.wdata[6:0];
        ADDR_PAT: pat_r <= reg_req.wdata;
        ADDR_PLEN: plen_r <= reg_req.wdata[5:0];
        ADDR_SYNC: syncc_r <= reg_req.wdata[23:0];
        default: ;
      endcase
    end
  end

  // Unmapped addresses read as zero; data stands only in the next cycle.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rdata_r <= 32'h0000_0000;
    end else if (reg_req.rd) begin
      case (reg_req.addr)
        ADDR_CTRL: rdata_r <= {25'h0, ctrl_r};
        ADDR_PAT: rdata_r <= pat_r;
        ADDR_PLEN: rdata_r <= {26'h0, plen_r};
        ADDR_SYNC: rdata_r <= {8'h0, syncc_r};
        ADDR_STAT: rdata_r <= {24'h0, armed_r, fsm_synced, lock_r, off_r};
        default: rdata_r <= 32'h0000_0000;
      endcase
    end else begin
      rdata_r <= 32'h0000_0000;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      p1_r <= 20'h00000;
      p2_r <= 20'h00000;
      slip_d_r <= 1'b0;
      realign_d_r <= 1'b0;
    end else begin
      p1_r <= rx_data_in;
      p2_r <= p1_r;
      slip_d_r <= slip_req;
      realign_d_r <= realign_en;
    end
  end

  assign slip_rise = slip_req && !slip_d_r;
  assign realign_rise = realign_en && !realign_d_r;

  wa_window u_window (
    .cur(rx_data_in),
    .p1(p1_r),
    .p2(p2_r),
    .wbits(wbits),
    .off(off_use),
    .plen(plen_use),
    .pattern(pat_use),
    .aligned(aligned),
    .match_vec(match_vec)
  );

  always_comb begin
    first_off = 5'h00;
    for (int i = 19; i >= 0; i--) begin
      if (match_vec[i]) begin
        first_off = 5'(i);
      end
    end
  end

  assign any_match = |match_vec;

  // In manual mode the ten bit aligner hunts whenever permitted; the others only once armed.
  always_comb begin
    case (mode)
      MODE_MANUAL: begin
        if (!double_w && wsel == W10) begin
          hunt_en = realign_en;
        end else begin
          hunt_en = armed_r;
        end
      end
      MODE_AUTO: hunt_en = !fsm_synced;
      default: hunt_en = 1'b0;
    endcase
  end

  // A match on the present boundary keeps it, so no needless jump.
  assign take = hunt_en && any_match;
  assign new_off = match_vec[off_r] ? off_r : first_off;
  assign off_use = take ? new_off : off_r;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      off_r <= 5'h00;
    end else if (mode == MODE_SLIP) begin
      if (slip_rise) begin
        off_r <= (off_r >= 5'(wbits - 5'h1)) ? 5'h00
                                             : 5'(off_r + 5'h1);
      end
    end else if (take) begin
      off_r <= new_off;
    end
  end

  // Armed after reset so double width locks the first pattern at once.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      armed_r <= 1'b1;
    end else if (realign_rise) begin
      armed_r <= 1'b1;
    end else if (take) begin
      armed_r <= 1'b0;
    end
  end

  // Double width lock: a permit edge wins over a lock in the same cycle.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      stat_r <= 1'b0;
    end else if (realign_rise) begin
      stat_r <= 1'b0;
    end else if (take) begin
      stat_r <= 1'b1;
    end
  end

  wa_sync_fsm u_sync (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .enable(auto_mode),
    .good_grp(match_vec[off_use]),
    .err_grp(code_err),
    .acq_n(acq_n),
    .lose_n(lose_n),
    .dec_n(dec_n),
    .synced(fsm_synced)
  );

  // A long slip pattern spans the previous output word and this one, so the
  // earlier word is taken as it left, not as it would read at the new offset.
  assign slip_cat = ({20'h0, aligned} << wbits) | {20'h0, data_out_r};
  assign slip_mask = (40'h1 << plen_use) - 40'h1;
  assign slip_pair = (slip_cat & slip_mask) == ({8'h00, pat_use} & slip_mask);
  assign hit_src = (mode == MODE_SLIP && plen_use > {1'b0, wbits}) ?
                   slip_pair : match_vec[off_use];

  // Status leaves with the word it belongs to, the pattern's last word.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      data_out_r <= 20'h00000;
      hit_r <= 1'b0;
    end else begin
      data_out_r <= aligned;
      hit_r <= hit_src;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      lock_r <= 1'b0;
    end else begin
      case (mode)
        MODE_MANUAL: begin
          if (double_w) begin
            lock_r <= stat_r || (take && !realign_rise);
          end else begin
            lock_r <= take && (armed_r || new_off != off_r);
          end
        end
        MODE_AUTO: lock_r <= fsm_synced;
        default: lock_r <= 1'b0;
      endcase
    end
  end

  assign reg_rdata = rdata_r;
  assign rx_data_out = data_out_r;
  assign pattern_hit = hit_r;
  assign lock_status = lock_r;

  a_slip_step: assert property (@(posedge clk_sys) disable iff (!rst_b)
    mode == MODE_SLIP && slip_rise && off_r < 5'(wbits - 5'h1) ##1
      mode == MODE_SLIP |-> off_r == 5'($past(off_r) + 5'h1))
    else $error("slip edge did not move the boundary by one bit");

  a_slip_pair: assert property (@(posedge clk_sys) disable iff (!rst_b)
    ##1 $stable(ctrl_r) && $stable(plen_r) && $stable(pat_r) &&
      mode == MODE_SLIP && wsel == W8 && plen_use == 6'h10 && hit_r |->
      {data_out_r[7:0], $past(data_out_r[7:0])} == pat_use[15:0])
    else $error("pattern hit without matching word pair");

  a_hit_cause: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !hit_r ##1 hit_r |-> $past(hit_src))
    else $error("pattern hit without a match");

  a_single_pulse: assert property (@(posedge clk_sys) disable iff (!rst_b)
    mode == MODE_MANUAL && wsel == W8 && lock_r |->
      !$past(armed_r, 2) || $past(take, 2) == 1'b0 || !lock_r ##1 !lock_r)
    else $error("single width lock longer than one cycle");

  a_dw_drop: assert property (@(posedge clk_sys) disable iff (!rst_b)
    mode == MODE_MANUAL && double_w && realign_rise ##1
      (mode == MODE_MANUAL && !take) |=> !lock_r)
    else $error("lock stayed high after permit edge");

  a_dw_hold: assert property (@(posedge clk_sys) disable iff (!rst_b)
    mode == MODE_MANUAL && double_w && stat_r && !realign_rise |=>
      stat_r ##1 lock_r)
    else $error("double width lock fell without permit edge");

  a_auto_width: assert property (@(posedge clk_sys) disable iff (!rst_b)
    auto_mode |-> wbits == WBITS_10)
    else $error("automatic mode on a width other than ten");

  a_auto_lock: assert property (@(posedge clk_sys) disable iff (!rst_b)
    auto_mode && $stable(ctrl_r) |=> lock_r == $past(fsm_synced))
    else $error("lock does not follow sync state");
endmodule : rx_word_boundary_aligner

// [bench/wa_fabric_model.sv]
// Stand-in for the fabric logic that steers the aligner: slip and permit.
// Assumes the aligner's parallel clock; requests move after rising edges.
`timescale 1ns/1ns
module wa_fabric_model (
  input wire logic clk_sys,
  output logic slip_req,
  output logic realign_en
);

  initial begin
    slip_req = 1'b0;
    realign_en = 1'b0;
  end

  // One clean edge, then a gap so the shifted word reaches the output first.
  task automatic slip(input int gap);
    @(posedge clk_sys);
    slip_req <= 1'b1;
    @(posedge clk_sys);
    slip_req <= 1'b0;
    repeat (gap) @(posedge clk_sys);
  endtask : slip

  // A permit edge; hold sets how long the level stays up.
  task automatic permit(input int hold, input int gap);
    @(posedge clk_sys);
    realign_en <= 1'b1;
    repeat (hold) @(posedge clk_sys);
    realign_en <= 1'b0;
    repeat (gap) @(posedge clk_sys);
  endtask : permit

endmodule : wa_fabric_model

// [bench/tb_top.sv]
// Self-checking bench for the receive word boundary aligner.
// Assumes one 50 MHz clock and the fabric model for slip and permit.
`timescale 1ns/1ns
module tb_top;
  import wa_pkg::*;

  logic clk_sys;
  logic rst_b;
  logic [19:0] rx_data_in;
  logic code_err;
  logic slip_req;
  logic realign_en;
  reg_req_t reg_req;
  logic [31:0] reg_rdata;
  logic [19:0] rx_data_out;
  logic pattern_hit;
  logic lock_status;
  logic lock_q;
  logic [31:0] rd;
  logic [8:0] acq_tab [4];
  logic [19:0] dw_word [2];
  int failures;
  int tests_run;
  int hits;
  int locks;
  int lock_cycles;

  rx_word_boundary_aligner i_rx_word_boundary_aligner (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .rx_data_in(rx_data_in),
    .code_err(code_err),
    .slip_req(slip_req),
    .realign_en(realign_en),
    .reg_req(reg_req),
    .reg_rdata(reg_rdata),
    .rx_data_out(rx_data_out),
    .pattern_hit(pattern_hit),
    .lock_status(lock_status)
  );

  wa_fabric_model i_wa_fabric_model (
    .clk_sys(clk_sys),
    .slip_req(slip_req),
    .realign_en(realign_en)
  );

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  // Event counters let scenarios judge pulses by differences, not by timing.
  always @(posedge clk_sys) begin
    if (pattern_hit === 1'b1) hits++;
    if (lock_status === 1'b1) lock_cycles++;
    if (lock_status === 1'b1 && lock_q !== 1'b1) locks++;
    lock_q = lock_status;
  end

  task automatic summarize();
    $display("Comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : summarize

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk_sys);
    reg_req <= '0;
  endtask : reg_wr

  task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(posedge clk_sys);
    reg_req <= '0;
    @(negedge clk_sys);
    d = reg_rdata;
  endtask : reg_rd

  task automatic rchk(input string what, input logic [3:0] a,
                      input logic [31:0] exp);
    logic [31:0] d;
    reg_rd(a, d);
    chk(what, exp, d);
  endtask : rchk

  // Ends mid-cycle so outputs are settled for the checks that follow.
  task automatic put(input logic [19:0] w, input logic e, input int n);
    repeat (n) begin
      @(posedge clk_sys);
      rx_data_in <= w;
      code_err <= e;
    end
    @(negedge clk_sys);
  endtask : put

  task automatic do_reset();
    @(posedge clk_sys);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'b1;
  endtask : do_reset

  task automatic auto_acq(input logic [19:0] w, input int n);
    put(w, 1'b0, n - 1);
    put(20'h0, 1'b0, 4);
    chk("lock early", 32'h0, 32'(lock_status));
    put(w, 1'b0, 1);
    put(20'h0, 1'b0, 4);
    chk("lock acquired", 32'h1, 32'(lock_status));
  endtask : auto_acq

  initial begin
    #(20 * 6000);
    failures++;
    summarize();
  end

  initial begin
    int h;
    int l;
    int c;
    rst_b = 1'b0;
    rx_data_in = 20'h0;
    code_err = 1'b0;
    reg_req = '0;
    acq_tab = '{PCIE_ACQ, XAUI_ACQ, GBE_ACQ, SRIO_ACQ};
    dw_word = '{20'h00f1e, 20'h0017c};
    repeat (10) @(posedge clk_sys);
    rst_b <= 1'b1;
    rchk("ctrl", ADDR_CTRL, {25'h0, CTRL_RST});
    rchk("pattern", ADDR_PAT, PAT_RST);
    rchk("plen", ADDR_PLEN, {26'h0, PLEN_RST});
    rchk("sync", ADDR_SYNC, {8'h0, SYNC_RST});
    rchk("status", ADDR_STAT, 32'h80);
    reg_wr(ADDR_STAT, 32'hffff_ffff);
    rchk("status ro", ADDR_STAT, 32'h80);
    rchk("unmapped", 4'hf, 32'h0);
    // Bit slip on a repeated word walks the boundary one bit per edge.
    put(20'h000f0, 1'b0, 4);
    h = hits;
    for (int i = 0; i < 4; i++) begin
      i_wa_fabric_model.slip(3);
      @(negedge clk_sys);
      chk("slip word", 32'h0f0 >> (i + 1), 32'(rx_data_out));
    end
    chk("slip hits", 32'h1, 32'(hits - h));
    reg_rd(ADDR_STAT, rd);
    chk("slip offset", 32'h04, rd & 32'h3f);
    // Eight bit manual: lock pulses once per permit edge, on the first match, moved or not.
    do_reset();
    reg_wr(ADDR_CTRL, 32'h04);
    put(20'h0, 1'b0, 2);
    i_wa_fabric_model.permit(1, 2);
    h = hits;
    l = locks;
    c = lock_cycles;
    for (int k = 0; k < 2; k++) begin
      put(20'h0001e, 1'b0, 1);
      put(20'h0000f, 1'b0, 1);
      put(20'h0, 1'b0, 4);
    end
    chk("m8 locks", 32'h1, 32'(locks - l));
    chk("m8 lock width", 32'h1, 32'(lock_cycles - c));
    chk("m8 hits", 32'h2, 32'(hits - h));
    for (int k = 0; k < 2; k++) begin
      if (k == 1) i_wa_fabric_model.permit(1, 2);
      put(20'h000f0, 1'b0, 1);
      put(20'h00078, 1'b0, 1);
      put(20'h0, 1'b0, 4);
      chk("m8 moved", 32'(k + 1), 32'(locks - l));
    end
    chk("m8 hits moved", 32'h3, 32'(hits - h));
    reg_rd(ADDR_STAT, rd);
    chk("m8 offset", 32'h03, rd & 32'h1f);
    // Double width manual, sixteen then twenty bits: lock is a level.
    for (int k = 0; k < 2; k++) begin
      do_reset();
      reg_wr(ADDR_CTRL, 32'(k + 6));
      reg_wr(ADDR_PAT, 32'(dw_word[k]));
      reg_wr(ADDR_PLEN, k == 0 ? 32'h10 : 32'h0a);
      put(dw_word[k], 1'b0, 1);
      put(20'h0, 1'b0, 3);
      chk("dw first lock", 32'h1, 32'(lock_status));
      put(20'h0, 1'b0, 6);
      chk("dw lock held", 32'h1, 32'(lock_status));
      i_wa_fabric_model.permit(1, 1);
      put(20'h0, 1'b0, 3);
      chk("dw lock drop", 32'h0, 32'(lock_status));
      put(dw_word[k], 1'b0, 1);
      put(20'h0, 1'b0, 3);
      chk("dw relock", 32'h1, 32'(lock_status));
    end
    // Basic automatic mode with programmed thresholds 3, 2 and 8.
    do_reset();
    reg_wr(ADDR_CTRL, 32'h09);
    reg_wr(ADDR_PAT, 32'h17c);
    reg_wr(ADDR_PLEN, 32'h0a);
    reg_wr(ADDR_SYNC, 32'h0007_0102);
    rchk("sync", ADDR_SYNC, 32'h0007_0102);
    auto_acq(20'h0017c, 3);
    put(20'h0, 1'b1, 1);
    put(20'h0, 1'b0, 4);
    chk("one error", 32'h1, 32'(lock_status));
    put(20'h0, 1'b1, 1);
    put(20'h0, 1'b0, 4);
    chk("sync lost", 32'h0, 32'(lock_status));
    // Protocol modes force the comma and fixed acquire counts.
    for (int p = 0; p < 4; p++) begin
      do_reset();
      reg_wr(ADDR_CTRL, 32'(p + 1) << 4);
      auto_acq(20'h0007c, int'(acq_tab[p]));
    end
    summarize();
  end

endmodule : tb_top
